// File: jbe_jitter_ecc.sv
// Summary of operation
// - Buffer of 2048 eight-bit symbols absorbs jitter
// - Offset steers servo divisor toward buffer centre
// - Divisor 588 centred, 589 below, 587 above
// - Offset of four frames forces write to centre
// - Recentre mutes output for 128 frames
// - Crystal-timed processing, C1 always before C2
// - C1 derives per-symbol flags, stored for C2
// - C1: none/one clear, two fix+set, more set
// - C2: none/one clear, else uses C1 flags
// - Two errors both flagged: fix, unless seven+
// - One match: no fix, set if five-
// - No match: no fix, set if two-
// - Three or more: set if two-, else copy
// - C2 result and flags written back to buffer
`include "jbe_defines.svh"

module jbe_jitter_ecc import jbe_pkg::*; #(
	parameter int DEPTH = `JBE_DEPTH,
	parameter int FRAME_CYCLES = int'(`JBE_FRAME_CYCLES)
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Demodulated symbols
	input wire logic symValid,
	input wire logic [7:0] symData,
	// Velocity servo divisor
	output logic [9:0] servoDivisor,
	// Syndrome engine handshake
	output logic decReq,
	output logic decStage,
	output jbe_frame_type decWord,
	input wire logic decAck,
	input wire jbe_dec_res_type decRes,
	// Symbols toward interpolation
	output logic outValid,
	output logic [7:0] outData,
	output logic outFlag,
	output logic outMute,
	output logic recentre
);

	localparam int AW = $clog2(DEPTH);
	localparam int SB = `JBE_SYM_BITS;
	localparam int FW = AW - SB;
	localparam int TW = $clog2(FRAME_CYCLES);
	localparam logic signed [FW-1:0] LIM = FW'(`JBE_JITTER_LIMIT);

	// Whole state of the block
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;   // Symbol buffer
		logic [DEPTH-1:0] flag;       // Per-symbol C2 flag
		logic [AW-1:0] wrPtr;         // Next symbol write address
		logic [FW-1:0] rdFrame;       // Next frame to process
		logic [FW-1:0] procBase;      // Frame now in the decoder
		logic [TW-1:0] tick;          // Crystal frame timer
		logic [7:0] muteCnt;          // Frames of mute left
		logic [9:0] divisor;          // Servo divisor
		jbe_phase_type phase;         // Processing phase
		jbe_frame_type word;          // Working codeword
		logic [31:0] c1Flags;         // C1 flag register
		logic [31:0] c2Flags;         // C2 flags of the frame
		jbe_dec_res_type res;         // Captured decoder answer
		logic [4:0] idx;              // Output symbol index
		logic outValid;
		logic [7:0] outData;
		logic outFlag;
		logic recentre;
	} jbe_state_type;

	jbe_state_type s_reg;
	jbe_state_type s_next;
	logic frameTick;                  // One cycle per crystal frame
	logic signed [FW-1:0] offset;     // Signed frame offset

	////////////////////////////////////////////////////////////////////
	// Helpers

	// XOR up to two error magnitudes into a codeword
	function automatic jbe_frame_type applyFix(
		input jbe_frame_type w,
		input jbe_dec_res_type r,
		input logic [1:0] n
	);
		jbe_frame_type f;
		f = w;
		if (n >= 2'h1) begin
			f[r.pos0] = f[r.pos0] ^ r.mag0;
		end
		if (n >= 2'h2) begin
			f[r.pos1] = f[r.pos1] ^ r.mag1;
		end
		return f;
	endfunction : applyFix

	// Number of C1 flags inside the C2 codeword
	function automatic logic [5:0] countFlags(input logic [31:0] f);
		logic [5:0] n;
		n = '0;
		for (int i = 0; i < `JBE_C2_SYMS; i++) begin
			n = n + 6'(f[i]);
		end
		return n;
	endfunction : countFlags

	// Write pointer frame against read frame, less the centre
	assign offset = FW'(s_reg.wrPtr[AW-1:SB] - s_reg.rdFrame
		- FW'(`JBE_CENTER_FRAMES));
	assign frameTick = (s_reg.tick == TW'(FRAME_CYCLES - 1));

	////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic [5:0] cnt;
		logic [1:0] hit;
		logic [1:0] nFix;
		logic setAll;
		logic copyC1;
		cnt = countFlags(s_reg.c1Flags);
		hit = 2'(s_reg.c1Flags[s_reg.res.pos0])
			+ 2'(s_reg.c1Flags[s_reg.res.pos1]);
		nFix = 2'h0;
		setAll = 1'b0;
		copyC1 = 1'b0;
		s_next = s_reg;
		s_next.outValid = 1'b0;
		s_next.recentre = 1'b0;
		s_next.tick = frameTick ? '0 : s_reg.tick + TW'(1);

		// Incoming symbols fill the buffer; flag cleared on arrival
		if (symValid) begin
			s_next.mem[s_reg.wrPtr] = symData;
			s_next.flag[s_reg.wrPtr] = 1'b0;
			s_next.wrPtr = s_reg.wrPtr + AW'(1);
		end

		// Centring check once per crystal frame
		if (frameTick) begin
			if (offset >= LIM || offset <= -LIM) begin
				// Beyond the window: recentre and mute
				s_next.wrPtr = {FW'(s_reg.rdFrame
					+ FW'(`JBE_CENTER_FRAMES)), SB'(0)};
				s_next.muteCnt = `JBE_MUTE_FRAMES;
				s_next.recentre = 1'b1;
				s_next.divisor = `JBE_DIV_CENTRE;
			end else begin
				// Trim the divisor toward centre
				if (offset < 0) begin
					s_next.divisor = `JBE_DIV_SLOW;
				end else if (offset > 0) begin
					s_next.divisor = `JBE_DIV_FAST;
				end else begin
					s_next.divisor = `JBE_DIV_CENTRE;
				end
				if (s_reg.muteCnt != 8'h00) begin
					s_next.muteCnt = s_reg.muteCnt - 8'h01;
				end
			end
			s_next.rdFrame = s_reg.rdFrame + FW'(1);
		end

		// Frame processing sequence
		case (s_reg.phase)
			PH_IDLE: begin
				// A frame that arrives while busy is left unprocessed
				if (frameTick) begin
					for (int i = 0; i < 32; i++) begin
						s_next.word[i] = s_reg.mem[{s_reg.rdFrame, SB'(i)}];
					end
					s_next.procBase = s_reg.rdFrame;
					s_next.phase = PH_C1_REQ;
				end
			end
			PH_C1_REQ, PH_C2_REQ: begin
				if (decAck) begin
					s_next.res = decRes;
					s_next.phase = (s_reg.phase == PH_C1_REQ)
						? PH_C1_FIX : PH_C2_FIX;
				end
			end
			PH_C1_FIX: begin
				// Correct up to two, flag two or more
				case (s_reg.res.errClass)
					ERR_NONE: nFix = 2'h0;
					ERR_ONE: nFix = 2'h1;
					ERR_TWO: nFix = 2'h2;
					default: nFix = 2'h0;
				endcase
				s_next.word = applyFix(s_reg.word, s_reg.res, nFix);
				s_next.c1Flags = (s_reg.res.errClass >= ERR_TWO)
					? 32'hFFFF_FFFF : 32'h0000_0000;
				s_next.phase = PH_C2_REQ;
			end
			PH_C2_FIX: begin
				case (s_reg.res.errClass)
					ERR_NONE: nFix = 2'h0;
					ERR_ONE: nFix = 2'h1;
					ERR_TWO: begin
						if (hit == 2'h2) begin
							// Both positions agree with C1
							if (cnt >= `JBE_C2_BOTH_LIMIT) begin
								copyC1 = 1'b1;
							end else begin
								nFix = 2'h2;
							end
						end else if (hit == 2'h1) begin
							// Only one agrees
							setAll = (cnt <= `JBE_C2_ONE_LIMIT);
							copyC1 = !setAll;
						end else begin
							// Neither agrees
							setAll = (cnt <= `JBE_C2_NONE_LIMIT);
							copyC1 = !setAll;
						end
					end
					default: begin
						// Uncorrectable
						setAll = (cnt <= `JBE_C2_NONE_LIMIT);
						copyC1 = !setAll;
					end
				endcase
				s_next.word = applyFix(s_reg.word, s_reg.res, nFix);
				s_next.c2Flags = setAll ? 32'hFFFF_FFFF
					: (copyC1 ? s_reg.c1Flags : 32'h0000_0000);
				// Corrected frame and flags go back to the buffer
				for (int i = 0; i < 32; i++) begin
					s_next.mem[{s_reg.procBase, SB'(i)}] = s_next.word[i];
					s_next.flag[{s_reg.procBase, SB'(i)}] = s_next.c2Flags[i];
				end
				s_next.idx = 5'h00;
				s_next.phase = PH_OUT;
			end
			PH_OUT: begin
				// Stream the frame out with its flags
				s_next.outValid = 1'b1;
				s_next.outData = s_reg.mem[{s_reg.procBase, s_reg.idx}];
				s_next.outFlag = s_reg.flag[{s_reg.procBase, s_reg.idx}];
				s_next.idx = s_reg.idx + 5'h01;
				if (s_reg.idx == 5'h1F) begin
					s_next.phase = PH_IDLE;
				end
			end
			default: s_next.phase = PH_IDLE;
		endcase

		// Synchronous reset: buffer is not cleared; a symbol or write-back in the same cycle still lands
		if (sys_rst) begin
			s_next.wrPtr = AW'(`JBE_CENTER_FRAMES) << SB;
			s_next.rdFrame = '0;
			s_next.tick = '0;
			s_next.muteCnt = 8'h00;
			s_next.divisor = `JBE_DIV_CENTRE;
			s_next.phase = PH_IDLE;
			s_next.c1Flags = 32'h0000_0000;
			s_next.c2Flags = 32'h0000_0000;
			s_next.idx = 5'h00;
			s_next.outValid = 1'b0;
			s_next.outData = 8'h00;
			s_next.outFlag = 1'b0;
			s_next.recentre = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		s_reg <= s_next;
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	assign servoDivisor = s_reg.divisor;
	assign decReq = (s_reg.phase == PH_C1_REQ) || (s_reg.phase == PH_C2_REQ);
	assign decStage = (s_reg.phase == PH_C2_REQ);
	assign decWord = s_reg.word;
	assign outValid = s_reg.outValid;
	assign outData = s_reg.outData;
	assign outFlag = s_reg.outFlag;
	assign outMute = (s_reg.muteCnt != 8'h00);
	assign recentre = s_reg.recentre;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	chk_divisor_values: assert property (
		servoDivisor inside {`JBE_DIV_CENTRE, `JBE_DIV_SLOW, `JBE_DIV_FAST})
		else $error("servo divisor outside its three values");
	chk_divisor_centre: assert property (
		frameTick && offset == 0 |=> servoDivisor == `JBE_DIV_CENTRE)
		else $error("centred offset did not give the standard divisor");
	chk_force_centre: assert property (
		frameTick && (offset >= LIM || offset <= -LIM)
		|=> recentre && s_reg.wrPtr[SB-1:0] == 0 && s_reg.wrPtr[AW-1:SB]
		== FW'($past(s_reg.rdFrame) + FW'(`JBE_CENTER_FRAMES)))
		else $error("overrun did not recentre the write address");
	chk_recentre_mute: assert property (
		recentre |-> outMute && s_reg.muteCnt == `JBE_MUTE_FRAMES)
		else $error("recentre did not load the mute count");
	chk_mute_end: assert property (
		frameTick && !(offset >= LIM || offset <= -LIM)
		&& s_reg.muteCnt == 8'h01 |=> !outMute)
		else $error("mute outlasted its frame count");
	chk_c1_first: assert property (
		$rose(decStage) |-> $past(s_reg.phase) == PH_C1_FIX)
		else $error("C2 request without a finished C1 stage");
	chk_c1_set_flags: assert property (
		s_reg.phase == PH_C1_FIX && s_reg.res.errClass >= ERR_TWO
		|=> s_reg.c1Flags == 32'hFFFF_FFFF)
		else $error("C1 flags not set for two or more errors");
	chk_c1_clear_flags: assert property (
		s_reg.phase == PH_C1_FIX && s_reg.res.errClass < ERR_TWO
		|=> s_reg.c1Flags == 32'h0000_0000)
		else $error("C1 flags not cleared for zero or one error");
	chk_c2_many_err: assert property (
		s_reg.phase == PH_C2_FIX && s_reg.res.errClass == ERR_MANY
		&& countFlags(s_reg.c1Flags) > `JBE_C2_NONE_LIMIT
		|=> s_reg.c2Flags == $past(s_reg.c1Flags))
		else $error("C1 flags not copied for uncorrectable word");
	chk_out_burst: assert property (
		s_reg.phase == PH_C2_FIX |=> ##1 outValid [*8])
		else $error("frame output burst broken");

	cov_recentre: cover property (recentre);
	cov_two_err: cover property (
		s_reg.phase == PH_C2_FIX && s_reg.res.errClass == ERR_TWO);
	cov_c2_request: cover property ($rose(decStage));
	cov_out_flag: cover property (outValid && outFlag);

endmodule : jbe_jitter_ecc

// File: jbe_defines.svh
`ifndef JBE_DEFINES_SVH
`define JBE_DEFINES_SVH

// Buffer geometry: 8-bit symbols, 32 symbols to a frame
`define JBE_DEPTH 2048
`define JBE_SYM_BITS 5
`define JBE_C2_SYMS 28
`define JBE_CENTER_FRAMES 32

// Jitter window in frames; reaching it forces a recentre
`define JBE_JITTER_LIMIT 4

// Velocity servo divisors on the playback clock side (588, 589, 587)
`define JBE_DIV_CENTRE 10'h24C
`define JBE_DIV_SLOW 10'h24D
`define JBE_DIV_FAST 10'h24B

// Mute length after a recentre, in frames (128)
`define JBE_MUTE_FRAMES 8'h80

// C2 flag thresholds on the C1 flag count (7, 5, 2)
`define JBE_C2_BOTH_LIMIT 6'h07
`define JBE_C2_ONE_LIMIT 6'h05
`define JBE_C2_NONE_LIMIT 6'h02

// Frame timing from the crystal: clk rate, playback clock rate in Hz
`define JBE_CLK_HZ 64'h0262_5A00
`define JBE_PBCLK_HZ 64'h0041_F208
`define JBE_DIV_NOMINAL 64'h0000_024C
`define JBE_FRAME_CYCLES \
	((`JBE_CLK_HZ * `JBE_DIV_NOMINAL) / `JBE_PBCLK_HZ)

`endif

// File: jbe_pkg.sv
package jbe_pkg;

	// One frame of symbols, index 0 first
	typedef logic [31:0][7:0] jbe_frame_type;

	// Error count class reported by the syndrome engine
	typedef enum logic [1:0] {
		ERR_NONE,
		ERR_ONE,
		ERR_TWO,
		ERR_MANY
	} jbe_err_type;

	// Decoder answer: class, two positions, two error magnitudes
	typedef struct packed {
		jbe_err_type errClass;
		logic [4:0] pos0;
		logic [4:0] pos1;
		logic [7:0] mag0;
		logic [7:0] mag1;
	} jbe_dec_res_type;

	// Processing phases of one frame
	typedef enum {
		PH_IDLE,
		PH_C1_REQ,
		PH_C1_FIX,
		PH_C2_REQ,
		PH_C2_FIX,
		PH_OUT
	} jbe_phase_type;

endpackage : jbe_pkg

// File: jbe_dec_model.sv
// Stand-in for the syndrome engine on the far side of the decoder port
module jbe_dec_model import jbe_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Request and pacing
	input wire logic decReq,
	input wire logic [7:0] slowCycles,
	input wire logic [31:0] rndWord,
	// Answer
	output logic decAck,
	output jbe_dec_res_type decRes
);
	logic [7:0] waitCnt; // Cycles spent on the current request

	////////////////////////////////////////////////////////////////////
	// Result inverts each cycle outside decAck, so a read an odd number of cycles late sees garbage
	// rather than a stale answer that would hide a sampling slip
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			decAck <= 1'b0;
			waitCnt <= 8'h00;
			decRes <= rndWord[27:0];
		end else if (decReq && !decAck && waitCnt == slowCycles) begin
			// Answer after the set delay; positions kept inside 0..27
			decAck <= 1'b1;
			waitCnt <= 8'h00;
			decRes.errClass <= jbe_err_type'(rndWord[31:30]);
			decRes.pos0 <= 5'(rndWord[6:2] % 5'h1C);
			decRes.pos1 <= 5'(rndWord[11:7] % 5'h1C);
			decRes.mag0 <= rndWord[19:12];
			decRes.mag1 <= rndWord[27:20];
		end else begin
			// Pulse lasts one cycle; count while a request waits
			decAck <= 1'b0;
			decRes <= ~decRes;
			if (decReq && !decAck) begin
				waitCnt <= waitCnt + 8'h01;
			end
		end
	end
endmodule : jbe_dec_model

// File: jbe_jitter_ecc_test.sv
module jbe_jitter_ecc_test import jbe_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int FC = 64; // Short frame keeps the run brief
	localparam int LIMIT = 90000; // Cycle ceiling for a hung run
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic symValid = 1'b0;
	logic [7:0] symData = 8'h00;
	logic [7:0] thr = 8'h00; // Symbol density, out of 256
	logic [7:0] slowCycles = 8'h00; // Engine answer delay
	logic [31:0] rnd = 32'h0000_0053;
	logic [9:0] servoDivisor;
	logic decReq, decStage, decAck, outValid, outFlag, outMute, recentre;
	logic [7:0] outData;
	jbe_frame_type decWord;
	jbe_dec_res_type decRes;
	logic [7:0] thrTab [5] = '{8'h80, 8'hF0, 8'h3C, 8'h00, 8'h84};
	logic [7:0] slowTab [5] = '{8'h00, 8'h09, 8'h03, 8'h0C, 8'h01};
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	int mem [2048] = '{default: -1}; // -1 marks a never-written symbol
	int wrPtr, rdFrame, timer, mute, off, fIdx, cnt, fl, c1Flag;
	int stageExp;
	int frameW [32];
	int expQ [$]; // Expected {data, flag}; -1 - flag for unknown symbols
	logic [9:0] expDiv;
	logic expRec;

	jbe_jitter_ecc #(.FRAME_CYCLES(FC)) dut (
		.clk(clk), .sys_rst(sys_rst), .symValid(symValid),
		.symData(symData), .servoDivisor(servoDivisor),
		.decReq(decReq), .decStage(decStage), .decWord(decWord),
		.decAck(decAck), .decRes(decRes), .outValid(outValid),
		.outData(outData), .outFlag(outFlag), .outMute(outMute),
		.recentre(recentre)
	);

	jbe_dec_model engine (
		.clk(clk), .sys_rst(sys_rst), .decReq(decReq),
		.slowCycles(slowCycles), .rndWord(rnd), .decAck(decAck),
		.decRes(decRes)
	);

	////////////////////////////////////////////////////////////////////
	// Clock, random source and comparison helpers
	always #12.5 clk = ~clk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction : xs

	task automatic check(input logic [31:0] seen, input logic [31:0] want,
		input string what);
		checked++;
		if (seen !== want) begin
			err_count++;
			$display("[ERR] %0t %s seen %0h want %0h", $time, what, seen, want);
		end
	endtask : check

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////
	// Random symbol stream; nothing is sent before reset has gone
	always @(posedge clk) begin
		rnd <= xs(rnd);
		symValid <= !sys_rst && rnd[7:0] < thr;
		symData <= rnd[15:8];
	end

	////////////////////////////////////////////////////////////////////
	// Pointer, servo and mute model, stepped on the same edges
	always @(posedge clk) begin
		expRec = 1'b0;
		if (sys_rst) begin
			wrPtr = 1024;
			rdFrame = 0;
			timer = 0;
			mute = 0;
			expDiv = 10'h24C;
			stageExp = 0;
			expQ.delete();
		end else begin
			// Offset is judged on the writer before this edge's symbol
			off = (wrPtr / 32 - rdFrame - 32) & 63;
			off = (off > 31) ? off - 64 : off;
			if (symValid) begin
				mem[wrPtr] = symData;
				wrPtr = (wrPtr + 1) % 2048;
			end
			if (timer == FC - 1) begin
				timer = 0;
				if (off <= -4 || off >= 4) begin
					// Overrun: snap the writer back to the centre
					expRec = 1'b1;
					mute = 128;
					expDiv = 10'h24C;
					wrPtr = ((rdFrame + 32) % 64) * 32;
				end else begin
					mute = (mute > 0) ? mute - 1 : 0;
					expDiv = (off < 0) ? 10'h24D
						: (off > 0) ? 10'h24B : 10'h24C;
				end
				// Snapshot the frame the engine will be handed
				fIdx = rdFrame;
				stageExp = 0;
				for (int i = 0; i < 32; i++) begin
					frameW[i] = mem[fIdx * 32 + i];
				end
				rdFrame = (rdFrame + 1) % 64;
			end else begin
				timer++;
			end
		end
	end

	// Registered servo outputs land one cycle after their tick
	always @(negedge clk) begin
		if (!sys_rst) begin
			check(32'(servoDivisor), 32'(expDiv), "divisor");
			check(32'(recentre), 32'(expRec), "recentre");
			check(32'(outMute), 32'(mute != 0), "mute");
		end
	end

	////////////////////////////////////////////////////////////////////
	// Correction model, fed with each answer the engine gives
	always @(posedge clk) begin
		if (!sys_rst && decReq && decAck) begin
			check(32'(decStage), 32'(stageExp), "stage order");
			// Word handed over: buffered frame, then C1-corrected frame
			for (int i = 0; i < 32; i++) begin
				if (frameW[i] >= 0) begin
					check(32'(decWord[i]), 32'(frameW[i]), "codeword");
				end
			end
			cnt = 28 * c1Flag;
			if (decRes.errClass == ERR_ONE ||
				(stageExp == 0 && decRes.errClass == ERR_TWO)) begin
				frameW[decRes.pos0] ^= int'(decRes.mag0);
			end
			if (stageExp == 0) begin
				if (decRes.errClass == ERR_TWO) begin
					frameW[decRes.pos1] ^= int'(decRes.mag1);
				end
				c1Flag = (decRes.errClass >= ERR_TWO) ? 1 : 0;
				stageExp = 1;
			end else begin
				// All-or-none C1 flags: a full set matches both positions
				fl = (decRes.errClass < ERR_TWO) ? 0 :
					(cnt <= 2) ? 1 : c1Flag;
				// Unknown symbols keep only their flag, coded as -1 - flag
				for (int i = 0; i < 32; i++) begin
					if (frameW[i] >= 0) begin
						mem[fIdx * 32 + i] = frameW[i];
					end
					expQ.push_back((frameW[i] >= 0)
						? frameW[i] * 2 + fl : -1 - fl);
				end
			end
		end
	end

	// Output stream against the queue; unknown symbols checked on their flag only
	always @(posedge clk) begin
		if (!sys_rst && outValid) begin
			if (expQ.size() == 0) begin
				check(32'h0000_0000, 32'h0000_0001, "extra output");
			end else if (expQ[0] < 0) begin
				check(32'(outFlag), 32'(-1 - expQ.pop_front()), "flag");
			end else begin
				check(32'({outData, outFlag}), 32'(expQ.pop_front()),
					"symbol");
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Phases of symbol density and engine delay, then the verdict
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		for (int p = 0; p < 5; p++) begin
			thr <= thrTab[p];
			slowCycles <= slowTab[p];
			repeat (FC * 250) @(posedge clk);
			$display("phase %0d done, checks %0d", p, checked);
		end
		stop_test;
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_count++;
			stop_test;
		end
	end
endmodule : jbe_jitter_ecc_test
